/* design/mms_cfg.svh */
// Constants for the management unit receiver: register offsets, fields, codes.
// Assumes inclusion by bare name from the receiver files and the bench top.
`ifndef MMS_CFG_SVH
`define MMS_CFG_SVH

// Register offsets on the software port (byte addresses)
`define MMS_REG_CTRL        8'h00
`define MMS_REG_PID         8'h04
`define MMS_REG_STATUS      8'h08
`define MMS_REG_ERR         8'h0C
`define MMS_REG_UNITS       8'h10
`define MMS_REG_ELEMS       8'h14

// Control register bits
`define MMS_CTRL_EN_BIT     0
`define MMS_CTRL_PIDCHK_BIT 1
`define MMS_CTRL_RESET      2'h0
`define MMS_PID_RESET       13'h0000

// Sticky error bits
`define MMS_ERR_PID         0
`define MMS_ERR_CONT        1
`define MMS_ERR_LEN         2
`define MMS_ERR_PAD         3
`define MMS_ERR_TRUNC       4
`define MMS_ERR_RSVD        5
`define MMS_ERR_W           6

// Element header byte layout, counted from the least significant bit
`define MMS_HDR_TYPE_HI     7
`define MMS_HDR_TYPE_LO     3
`define MMS_HDR_FROM_PREV   2
`define MMS_HDR_TO_NEXT     1
`define MMS_HDR_MORE        0

// Element type codes
`define MMS_T_CAPREQ        5'h00
`define MMS_T_MONCTL        5'h01
`define MMS_T_MSGHDR        5'h03
`define MMS_T_REJECT        5'h04
`define MMS_T_CHANNEL       5'h05
`define MMS_T_SRCADDR       5'h06
`define MMS_T_DSTADDR       5'h07
`define MMS_T_FWDSTREAM     5'h08
`define MMS_T_RETSTREAM     5'h09
`define MMS_T_CONNTYPE      5'h0A
`define MMS_T_FWDPROF       5'h0B
`define MMS_T_RETPROF       5'h0C
`define MMS_T_SIGNON        5'h0D
`define MMS_T_KEYMAIN       5'h11
`define MMS_T_KEYQUICK      5'h13
`define MMS_T_KEYEXPL       5'h15
`define MMS_T_ADAPT         5'h16
`define MMS_T_WAIT          5'h1F

// Fixed body lengths; zero means variable length
`define MMS_LEN_VAR         10'h000
`define MMS_LEN_1           10'h001
`define MMS_LEN_2           10'h002
`define MMS_LEN_3           10'h003
`define MMS_LEN_4           10'h004
`define MMS_LEN_6           10'h006
`define MMS_LEN_8           10'h008

`define MMS_ZERO_BYTE       8'h00
`endif

/* design/mms_pkg.sv */
// Types shared by the management unit receiver files.
// Assumes mms_cfg.svh supplies every numeric constant.
package mms_pkg;
    // Receiver parsing states
    typedef enum logic [2:0] {
        MMS_S_IDLE    = 3'b000,
        MMS_S_SESS_HI = 3'b001,
        MMS_S_SESS_LO = 3'b010,
        MMS_S_EHDR    = 3'b011,
        MMS_S_ELEN    = 3'b100,
        MMS_S_BODY    = 3'b101,
        MMS_S_PAD     = 3'b110,
        MMS_S_DROP    = 3'b111
    } mms_state_t;
endpackage

/* design/mms_hdr_decode.sv */
// Decoder for the first byte of an information element.
// Assumes a byte that is known to be an element header.
`timescale 1ns/1ps
`include "mms_cfg.svh"
module mms_hdr_decode (
    input  wire logic [7:0] hdr_in,        // Element header byte
    output logic      [4:0] type_out,      // Element type code
    output logic            from_prev_out, // Continues an earlier unit
    output logic            to_next_out,   // Continues into a later unit
    output logic            more_out,      // Another element follows
    output logic            known_out,     // Type code is defined
    output logic      [9:0] body_len_out   // Fixed body length, zero if variable
);
    // Field split, type in the top five bits
    assign type_out      = hdr_in[`MMS_HDR_TYPE_HI:`MMS_HDR_TYPE_LO];
    assign from_prev_out = hdr_in[`MMS_HDR_FROM_PREV];
    assign to_next_out   = hdr_in[`MMS_HDR_TO_NEXT];
    assign more_out      = hdr_in[`MMS_HDR_MORE];

    // Type table: defined codes and their body lengths
    always_comb begin
        known_out    = 1'b1;
        body_len_out = `MMS_LEN_VAR;
        case (type_out)
            `MMS_T_CAPREQ, `MMS_T_MONCTL, `MMS_T_ADAPT: body_len_out = `MMS_LEN_2;
            `MMS_T_MSGHDR:                   body_len_out = `MMS_LEN_4;
            `MMS_T_REJECT:                   body_len_out = `MMS_LEN_2;
            `MMS_T_CHANNEL:                  body_len_out = `MMS_LEN_1;
            `MMS_T_SRCADDR, `MMS_T_DSTADDR:  body_len_out = `MMS_LEN_6;
            `MMS_T_FWDSTREAM, `MMS_T_RETSTREAM: body_len_out = `MMS_LEN_3;
            `MMS_T_CONNTYPE:                 body_len_out = `MMS_LEN_1;
            `MMS_T_FWDPROF, `MMS_T_RETPROF:  body_len_out = `MMS_LEN_3;
            `MMS_T_SIGNON:                   body_len_out = `MMS_LEN_8;
            `MMS_T_WAIT:                     body_len_out = `MMS_LEN_VAR;
            `MMS_T_KEYMAIN, `MMS_T_KEYQUICK, `MMS_T_KEYEXPL: body_len_out = `MMS_LEN_VAR;
            default:                         known_out = 1'b0;
        endcase
    end
endmodule

/* design/mms_rx.sv */
// Hub-side receiver for terminal control and management units.
// Assumes one unit byte per cycle on byte_valid_in, unit_start_in on the first
// byte and unit_end_in on the last, all synchronous to clk_in.
//
// Functional notes
// - Unit payload opens with three identity bytes
// - Group byte, then two-byte session identifier
// - Header byte top five bits: type
// - Sixth bit: element continues from before
// - Seventh bit: element continues onward
// - Eighth bit: another element follows
// - Second byte is segment length, fragment follows
// - Message header type 03, four bytes
// - Reject 04 two bytes; channel 05 one
// - Addresses 06 and 07, six bytes
// - Stream identifiers 08 and 09, three bytes
// - Connection type 0A, one byte
// - Profiles 0B and 0C, three bytes
// - Sign-on 0D eight bytes; wait 1F
// - Key exchange responses 11, 13, 15
`timescale 1ns/1ps
`include "mms_cfg.svh"
module mms_rx #(
    parameter int PID_W = 13                  // Stream identifier width
) (
    input  wire logic             clk_in,          // System clock, 125 MHz
    input  wire logic             rst_in,          // Synchronous reset, active high
    input  wire logic [7:0]       addr_in,         // Register byte address
    input  wire logic [31:0]      wdata_in,        // Register write data
    input  wire logic             wr_in,           // Register write strobe
    input  wire logic             rd_in,           // Register read strobe
    output logic      [31:0]      rdata_out,       // Read data, cycle after rd_in
    input  wire logic             byte_valid_in,   // Unit byte present
    input  wire logic [7:0]       byte_in,         // Unit byte
    input  wire logic             unit_start_in,   // First byte of a unit
    input  wire logic             unit_end_in,     // Last byte of a unit
    input  wire logic [PID_W-1:0] unit_pid_in,     // Stream identifier of the unit
    output logic                  elem_valid_out,  // Element body byte valid
    output logic      [7:0]       elem_data_out,   // Element body byte
    output logic      [4:0]       elem_type_out,   // Type of the element
    output logic                  elem_first_out,  // First body byte of element
    output logic                  elem_last_out,   // Last body byte of element
    output logic      [7:0]       group_out,       // Group byte of the last accepted unit
    output logic      [15:0]      session_out      // Session identifier of the last accepted unit
);
    import mms_pkg::*;

    // Software registers
    logic [1:0]            ctrl;           // Enable and identifier check
    logic [PID_W-1:0]      pid;            // Expected stream identifier
    logic [`MMS_ERR_W-1:0] err;            // Sticky error flags
    logic [31:0]           unit_cnt;       // Units accepted
    logic [31:0]           elem_cnt;       // Elements completed

    // Parser state
    mms_state_t state;                     // Current state
    mms_state_t next_state;                // State after this byte
    logic [4:0] cur_type;                  // Type of element being read
    logic       cur_to_next;               // Current element continues onward
    logic       cur_more;                  // Another element follows
    logic       cur_known;                 // Current type is defined
    logic       cur_first;                 // Current segment opens the element
    logic [9:0] cur_exp;                   // Fixed length of current type
    logic [7:0] seg_left;                  // Fragment bytes still to come
    logic [9:0] acc;                       // Element bytes announced so far
    logic       cont_open;                 // Element waits for a later unit
    logic [4:0] cont_type;                 // Type of the waiting element
    logic       emit_first;                // Next emitted byte opens the segment

    // Header byte decode
    logic [4:0] d_type;                    // Decoded type
    logic       d_from_prev;               // Decoded continue-from-before
    logic       d_to_next;                 // Decoded continue-onward
    logic       d_more;                    // Decoded more-follows
    logic       d_known;                   // Decoded type is defined
    logic [9:0] d_len;                     // Decoded fixed length

    mms_hdr_decode u_dec (
        .hdr_in        (byte_in),
        .type_out      (d_type),
        .from_prev_out (d_from_prev),
        .to_next_out   (d_to_next),
        .more_out      (d_more),
        .known_out     (d_known),
        .body_len_out  (d_len)
    );

    // Byte classification
    wire        take       = byte_valid_in;
    wire        opening    = take && unit_start_in;
    wire        pid_ok     = !ctrl[`MMS_CTRL_PIDCHK_BIT] || (unit_pid_in == pid);
    wire        accept     = opening && ctrl[`MMS_CTRL_EN_BIT] && pid_ok;
    wire        in_hdr     = take && !unit_start_in && (state == MMS_S_EHDR);
    wire        in_len     = take && !unit_start_in && (state == MMS_S_ELEN);
    wire        in_body    = take && !unit_start_in && (state == MMS_S_BODY);
    wire        in_pad     = take && !unit_start_in && (state == MMS_S_PAD);
    wire [9:0]  acc_sum    = acc + {2'b00, byte_in};
    wire        zero_seg   = in_len && (byte_in == `MMS_ZERO_BYTE);
    wire        body_last  = in_body && (seg_left == 8'h01);
    wire        seg_done   = zero_seg || body_last;
    wire        elem_done  = seg_done && !cur_to_next;
    wire        len_bad    = elem_done && (cur_exp != `MMS_LEN_VAR) && (acc != cur_exp);
    wire        cont_bad   = in_hdr && (d_from_prev ? (!cont_open || d_type != cont_type)
                                                    : cont_open);
    wire        pad_bad    = in_pad && (byte_in != `MMS_ZERO_BYTE);
    wire        rsvd_seen  = in_hdr && !d_known;
    wire        ends_clean = (next_state == MMS_S_PAD) || (next_state == MMS_S_DROP)
                             || (next_state == MMS_S_IDLE);
    wire        trunc      = take && unit_end_in && !ends_clean;
    wire        emit       = in_body && cur_known;

    // Next state for the current byte
    always_comb begin
        next_state = state;
        if (opening) begin
            next_state = accept ? MMS_S_SESS_HI : MMS_S_DROP;
        end else if (take) begin
            case (state)
                MMS_S_SESS_HI: next_state = MMS_S_SESS_LO;
                MMS_S_SESS_LO: next_state = MMS_S_EHDR;
                MMS_S_EHDR:    next_state = MMS_S_ELEN;
                MMS_S_ELEN: begin
                    if (byte_in != `MMS_ZERO_BYTE) begin
                        next_state = MMS_S_BODY;
                    end else begin
                        next_state = cur_more ? MMS_S_EHDR : MMS_S_PAD;
                    end
                end
                MMS_S_BODY: begin
                    if (body_last) begin
                        next_state = cur_more ? MMS_S_EHDR : MMS_S_PAD;
                    end
                end
                default:       next_state = state;
            endcase
        end
    end

    // State register, back to idle at the end of every unit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= MMS_S_IDLE;
        end else if (take && unit_end_in) begin
            state <= MMS_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Identity bytes of the unit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            group_out   <= 8'h00;
            session_out <= 16'h0000;
        end else if (accept) begin
            group_out   <= byte_in;
        end else if (take && state == MMS_S_SESS_HI) begin
            session_out <= {byte_in, session_out[7:0]};
        end else if (take && state == MMS_S_SESS_LO) begin
            session_out <= {session_out[15:8], byte_in};
        end
    end

    // Element header fields of the current segment
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur_type    <= 5'h00;
            cur_to_next <= 1'b0;
            cur_more    <= 1'b0;
            cur_known   <= 1'b0;
            cur_first   <= 1'b0;
            cur_exp     <= `MMS_LEN_VAR;
        end else if (in_hdr) begin
            cur_type    <= d_type;
            cur_to_next <= d_to_next;
            cur_more    <= d_more;
            cur_known   <= d_known;
            cur_first   <= !d_from_prev;
            cur_exp     <= d_len;
        end
    end

    // Segment counter and element length accumulation
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seg_left <= 8'h00;
            acc      <= 10'h000;
        end else if (in_hdr && !d_from_prev) begin
            acc      <= 10'h000;
        end else if (in_len) begin
            seg_left <= byte_in;
            acc      <= acc_sum;
        end else if (in_body) begin
            seg_left <= seg_left - 8'h01;
        end
    end

    // Pending continuation across units
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cont_open <= 1'b0;
            cont_type <= 5'h00;
        end else if (seg_done) begin
            cont_open <= cur_to_next;
            cont_type <= cur_type;
        end
    end

    // Element body output, first and last markers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            elem_valid_out <= 1'b0;
            elem_data_out  <= 8'h00;
            elem_type_out  <= 5'h00;
            elem_first_out <= 1'b0;
            elem_last_out  <= 1'b0;
            emit_first     <= 1'b0;
        end else begin
            elem_valid_out <= emit;
            elem_data_out  <= emit ? byte_in : 8'h00;
            elem_type_out  <= cur_type;
            elem_first_out <= emit && emit_first && cur_first;
            elem_last_out  <= emit && body_last && !cur_to_next;
            if (in_len) begin
                emit_first <= 1'b1;
            end else if (in_body) begin
                emit_first <= 1'b0;
            end
        end
    end

    // Register writes; error flags set wins over write-one-to-clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl <= `MMS_CTRL_RESET;
            pid  <= `MMS_PID_RESET;
            err  <= '0;
        end else begin
            if (wr_in && addr_in == `MMS_REG_CTRL) begin
                ctrl <= wdata_in[1:0];
            end
            if (wr_in && addr_in == `MMS_REG_PID) begin
                pid <= wdata_in[PID_W-1:0];
            end
            err <= (err & ~((wr_in && addr_in == `MMS_REG_ERR) ? wdata_in[`MMS_ERR_W-1:0] : '0))
                 | {rsvd_seen, trunc, pad_bad, len_bad, cont_bad, opening && !accept
                    && ctrl[`MMS_CTRL_EN_BIT]};
        end
    end

    // Unit and element counters
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            unit_cnt <= 32'h0000_0000;
            elem_cnt <= 32'h0000_0000;
        end else begin
            if (accept) begin
                unit_cnt <= unit_cnt + 32'h0000_0001;
            end
            if (elem_done && cur_known) begin
                elem_cnt <= elem_cnt + 32'h0000_0001;
            end
        end
    end

    // Read mux, unmapped addresses read zero
    logic [31:0] rd_mux;                   // Selected read word
    always_comb begin
        case (addr_in)
            `MMS_REG_CTRL:   rd_mux = {30'h0, ctrl};
            `MMS_REG_PID:    rd_mux = {{(32-PID_W){1'b0}}, pid};
            `MMS_REG_STATUS: rd_mux = {cont_open, 3'h0, cont_type[3:0], group_out, session_out};
            `MMS_REG_ERR:    rd_mux = {{(32-`MMS_ERR_W){1'b0}}, err};
            `MMS_REG_UNITS:  rd_mux = unit_cnt;
            `MMS_REG_ELEMS:  rd_mux = elem_cnt;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

/* testbench/mms_rx_assertions.sv */
// Checker for the management unit receiver, watching its ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module mms_rx_checker #(
    parameter int PID_W = 13                  // Stream identifier width
) (
    input wire logic             clk_in,
    input wire logic             rst_in,
    input wire logic [7:0]       addr_in,
    input wire logic [31:0]      wdata_in,
    input wire logic             wr_in,
    input wire logic             rd_in,
    input wire logic [31:0]      rdata_out,
    input wire logic             byte_valid_in,
    input wire logic [7:0]       byte_in,
    input wire logic             unit_start_in,
    input wire logic [PID_W-1:0] unit_pid_in,
    input wire logic             elem_valid_out,
    input wire logic [7:0]       elem_data_out,
    input wire logic [4:0]       elem_type_out,
    input wire logic             elem_first_out,
    input wire logic             elem_last_out,
    input wire logic [7:0]       group_out,
    input wire logic [15:0]      session_out
);
    logic             en;     // Enable copy
    logic             chk_on; // Id check copy
    logic             ok;     // Unit accepted
    logic [PID_W-1:0] pid;    // Expected id copy
    wire acc = byte_valid_in && unit_start_in && en && (!chk_on || unit_pid_in == pid);
    // Track control writes and acceptance of each unit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {en, chk_on, ok, pid} <= '0;
        end else begin
            if (wr_in && addr_in == 8'h00) {chk_on, en} <= wdata_in[1:0];
            if (wr_in && addr_in == 8'h04) pid <= wdata_in[PID_W-1:0];
            if (byte_valid_in && unit_start_in) ok <= acc;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_GROUP: assert property (acc |=> group_out == $past(byte_in))
        else $error("group wrong");
    AST_SESSION: assert property ($past(acc, 2) && $past(byte_valid_in) && !$past(unit_start_in)
        && byte_valid_in && !unit_start_in |=> session_out == {$past(byte_in, 2), $past(byte_in)})
        else $error("session wrong");
    AST_KNOWN: assert property (elem_valid_out |-> elem_type_out inside {[5'h00:5'h01], [5'h03:5'h0D],
        5'h11, 5'h13, 5'h15, 5'h16, 5'h1F}) else $error("reserved type out");
    AST_FLAGS: assert property (elem_first_out || elem_last_out |-> elem_valid_out)
        else $error("flag without data");
    AST_DATA: assert property (elem_valid_out |-> $past(byte_valid_in) && elem_data_out == $past(byte_in))
        else $error("data mismatch");
    AST_ZERO: assert property (!elem_valid_out |-> elem_data_out == 8'h00)
        else $error("idle data nonzero");
    AST_GATE: assert property (elem_valid_out |-> $past(ok))
        else $error("refused unit out");
    AST_STATUS: assert property (rd_in && addr_in == 8'h08 |=>
        rdata_out[23:0] == {$past(group_out), $past(session_out)}) else $error("status ids wrong");
    AST_UNMAPPED: assert property (rd_in && !(addr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})
        |=> rdata_out == 32'h0) else $error("unmapped nonzero");
    cover property (acc);
    cover property (elem_first_out && elem_last_out);
    cover property (elem_valid_out && !elem_first_out);
endmodule
bind mms_rx mms_rx_checker #(.PID_W(PID_W)) u_chk (.*);

/* testbench/mms_term_model.sv */
// Terminal model that builds and sends control and management units.
// Assumes the bench fills a unit through the tasks, then calls send.
`timescale 1ns/1ps
module mms_term_model #(
    parameter int PID_W = 13                  // Stream identifier width
) (
    input  wire logic             clk_in,     // System clock
    output logic                  vld_out,    // Byte present
    output logic      [7:0]       byte_out,   // Unit byte
    output logic                  start_out,  // First byte of unit
    output logic                  end_out,    // Last byte of unit
    output logic      [PID_W-1:0] pid_out     // Stream id with first byte
);
    logic [7:0] q[$]; // Unit being built
    initial begin
        {vld_out, start_out, end_out} = 3'b000;
    end
    // Group byte then session id, high byte first
    task automatic ids(input logic [7:0] g, input logic [15:0] s);
        q = {g, s[15:8], s[7:0]};
    endtask
    // Header repeated per segment, then length and fragment
    task automatic elem(input logic [4:0] t, input logic [2:0] f, input int n, input logic [7:0] d0);
        q.push_back({t, f});
        q.push_back(8'(n));
        for (int i = 0; i < n; i++) q.push_back(d0 + 8'(i));
    endtask
    // Fill after the last element, zero unless a fault is wanted
    task automatic pad(input int n, input logic [7:0] v);
        repeat (n) q.push_back(v);
    endtask
    // Send with the logon stream id one idle cycle after the ids
    task automatic send(input logic [PID_W-1:0] pid);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge clk_in);
            if (i == 3) begin
                vld_out <= 1'b0;
                @(posedge clk_in);
            end
            vld_out <= 1'b1;
            byte_out <= q[i];
            start_out <= (i == 0);
            end_out <= (i == q.size() - 1);
            pid_out <= (i == 0) ? pid : ~pid;
        end
        @(posedge clk_in);
        vld_out <= 1'b0;
        byte_out <= ~q[q.size() - 1];
        end_out <= 1'b0;
        q.delete();
        repeat (3) @(posedge clk_in);
    endtask
endmodule

/* testbench/mms_rx_tb_top.sv */
// Self-checking bench for the management unit receiver.
// Assumes the terminal model and the checker are compiled before it.
`timescale 1ns/1ps
`include "mms_cfg.svh"
module mms_rx_tb_top;
    logic        clk_in = 1'b0;
    logic        rst_in, wr_in, rd_in;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in;
    logic [31:0] rdata_out;
    logic        vld, st, en_d, ev, ef, el;
    logic [7:0]  bt, ed, grp;
    logic [4:0]  et;
    logic [15:0] ses;
    logic [12:0] pid;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [14:0] got[$];          // Emitted {type, first, last, data}
    mms_rx DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .byte_valid_in(vld), .byte_in(bt),
        .unit_start_in(st), .unit_end_in(en_d), .unit_pid_in(pid), .elem_valid_out(ev), .elem_data_out(ed),
        .elem_type_out(et), .elem_first_out(ef), .elem_last_out(el), .group_out(grp), .session_out(ses));
    mms_term_model u (.clk_in(clk_in), .vld_out(vld), .byte_out(bt), .start_out(st),
        .end_out(en_d), .pid_out(pid));
    always #4 clk_in = ~clk_in;
    // Collect body bytes and cut a hang short
    always @(posedge clk_in) begin
        cyc++;
        if (ev === 1'b1) got.push_back({et, ef, el, ed});
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask
    // Compare n emitted body bytes of one segment
    task automatic pop_chk(input logic [4:0] t, input int n, input logic [7:0] d0, input logic f, input logic l);
        for (int i = 0; i < n; i++) begin
            chk(got.size() > 0 ? 32'(got.pop_front()) : 32'hFFFFFFFF,
                32'({t, f && (i == 0), l && (i == n - 1), d0 + 8'(i)}));
        end
    endtask
    // Disabled receiver ignores units; unmapped read is zero
    task automatic t_idle();
        rc(`MMS_REG_CTRL, 32'h0);
        rc(8'h18, 32'h0);
        u.ids(8'h01, 16'h0203);
        u.elem(`MMS_T_CHANNEL, 3'b000, 1, 8'h5A);
        u.send(13'h0000);
        chk(got.size(), 32'h0);
        rc(`MMS_REG_UNITS, 32'h0);
    endtask
    // Every defined type with its body length, one unit each
    task automatic t_types();
        logic [4:0]  ty[18] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B,
                                5'h0C, 5'h0D, 5'h16, 5'h11, 5'h13, 5'h15, 5'h1F};
        int          ln[18] = '{2, 2, 4, 2, 1, 6, 6, 3, 3, 1, 3, 3, 8, 2, 5, 5, 5, 5};
        wr(`MMS_REG_CTRL, 32'h1);
        for (int i = 0; i < 18; i++) begin
            u.ids(8'(i), 16'hA000 + 16'(i));
            u.elem(ty[i], 3'b000, ln[i], 8'(i * 16));
            u.pad(3, 8'h00);
            u.send(13'h0000);
            pop_chk(ty[i], ln[i], 8'(i * 16), 1'b1, 1'b1);
        end
        chk(grp, 8'h11);
        chk(ses, 16'hA011);
        rc(`MMS_REG_STATUS, 32'h0F11A011);
        rc(`MMS_REG_UNITS, 32'h12);
        rc(`MMS_REG_ELEMS, 32'h12);
        rc(`MMS_REG_ERR, 32'h0);
    endtask
    // Three elements in one unit, the middle one reserved
    task automatic t_multi();
        u.ids(8'h21, 16'h0102);
        u.elem(`MMS_T_CHANNEL, 3'b001, 1, 8'h31);
        u.elem(5'h0E, 3'b001, 2, 8'h70);
        u.elem(`MMS_T_CONNTYPE, 3'b000, 1, 8'h41);
        u.pad(4, 8'h00);
        u.send(13'h0000);
        pop_chk(`MMS_T_CHANNEL, 1, 8'h31, 1'b1, 1'b1);
        pop_chk(`MMS_T_CONNTYPE, 1, 8'h41, 1'b1, 1'b1);
        chk(got.size(), 32'h0);
        rc(`MMS_REG_ERR, 32'h20);
        wr(`MMS_REG_ERR, 32'h7F);
        rc(`MMS_REG_ERR, 32'h0);
    endtask
    // Address split 4 + 2 over two units, then an orphan continuation
    task automatic t_split();
        u.ids(8'h22, 16'h0304);
        u.elem(`MMS_T_SRCADDR, 3'b010, 4, 8'h50);
        u.pad(2, 8'h00);
        u.send(13'h0000);
        u.ids(8'h22, 16'h0304);
        u.elem(`MMS_T_SRCADDR, 3'b100, 2, 8'h54);
        u.send(13'h0000);
        pop_chk(`MMS_T_SRCADDR, 4, 8'h50, 1'b1, 1'b0);
        pop_chk(`MMS_T_SRCADDR, 2, 8'h54, 1'b0, 1'b1);
        rc(`MMS_REG_ERR, 32'h0);
        u.ids(8'h22, 16'h0304);
        u.elem(`MMS_T_CHANNEL, 3'b100, 1, 8'h60);
        u.send(13'h0000);
        rc(`MMS_REG_ERR, 32'h6);
        wr(`MMS_REG_ERR, 32'h7F);
        got.delete();
    endtask
    // Stream id check refuses a unit with a foreign id
    task automatic t_pid();
        wr(`MMS_REG_PID, 32'h0123);
        wr(`MMS_REG_CTRL, 32'h3);
        u.ids(8'h23, 16'h0506);
        u.elem(`MMS_T_CHANNEL, 3'b000, 1, 8'h61);
        u.send(13'h0124);
        chk(got.size(), 32'h0);
        rc(`MMS_REG_ERR, 32'h1);
        u.ids(8'h23, 16'h0506);
        u.elem(`MMS_T_CHANNEL, 3'b000, 1, 8'h62);
        u.send(13'h0123);
        pop_chk(`MMS_T_CHANNEL, 1, 8'h62, 1'b1, 1'b1);
        wr(`MMS_REG_ERR, 32'h7F);
        wr(`MMS_REG_CTRL, 32'h1);
    endtask
    // Wrong segment length and nonzero fill are both flagged
    task automatic t_bad();
        u.ids(8'h24, 16'h0708);
        u.elem(`MMS_T_CHANNEL, 3'b000, 2, 8'h80);
        u.pad(2, 8'h55);
        u.send(13'h0000);
        rc(`MMS_REG_ERR, 32'h0C);
        got.delete();
    endtask
    initial begin
        rst_in = 1'b1;
        {addr_in, wdata_in, wr_in, rd_in} = '0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        t_idle();
        t_types();
        t_multi();
        t_split();
        t_pid();
        t_bad();
        end_sim();
    end
endmodule
